// ### rtl/bcr_cfg.svh
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH

// Register addresses on the backport bus
`define BCR_ADDR_W 24
`define BCR_DATA_W 16
`define BCR_CSR_ADDR 24'h40FF0E
`define BCR_EVT_ADDR 24'h40FF1E
`define BCR_SEL_HI 23
`define BCR_SEL_LO 22
`define BCR_SEL_GATE 2'h2

// Control/status bit positions
`define BCR_CSR_RX_PATH_ON 0
`define BCR_CSR_SOFT_CLEAR 1
`define BCR_CSR_ABSENT 2
`define BCR_CSR_BOOT_SEL 3
`define BCR_CSR_TX_LIST_BAD 4
`define BCR_CSR_RX_LIST_BAD 5
`define BCR_CSR_IRQ_GATE 6
`define BCR_CSR_TX_DONE 7
`define BCR_CSR_INNER_LOOP 8
`define BCR_CSR_OUTER_LOOP 9
`define BCR_CSR_WATCHDOG 10
`define BCR_CSR_FUSE_GOOD 12
`define BCR_CSR_LINK_SENSE 13
`define BCR_CSR_PARITY 14
`define BCR_CSR_RX_DONE 15

// Control/status masks
`define BCR_CSR_HOST_WR 16'h87CB
`define BCR_CSR_CPU_WR 16'hC2B4
`define BCR_CSR_STORED 16'hC7FF
`define BCR_CSR_KEEP 16'h0030
`define BCR_CSR_RST 16'h0000

// Event register bit positions and masks
`define BCR_EVT_TIMER 0
`define BCR_EVT_CSR_WR 1
`define BCR_EVT_VEC_WR 2
`define BCR_EVT_TXL_WR 3
`define BCR_EVT_RXL_WR 4
`define BCR_EVT_STRAP_ONE 5
`define BCR_EVT_ROM_SEL 6
`define BCR_EVT_STRAP_TWO 12
`define BCR_EVT_LAMP_LO 13
`define BCR_EVT_WR 16'hE05F
`define BCR_EVT_FLAGS 16'h001F
`define BCR_EVT_KEEP 16'hE000
`define BCR_EVT_RST 16'h0000

`endif

// ### rtl/bcr_pkg.sv
package bcr_pkg;

    typedef struct packed {
        logic valid;
        logic wr;
        logic [23:0] addr;
        logic [15:0] wdata;
    } bcr_req_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } bcr_rsp_t;

    typedef struct packed {
        logic rx_path_on;
        logic boot_load_sel;
        logic irq_gate;
        logic tx_done_irq;
        logic inner_loop;
        logic outer_loop;
        logic watchdog_on;
        logic rx_done_irq;
        logic absent_flag;
        logic tx_list_bad;
        logic rx_list_bad;
        logic parity_fault;
    } bcr_ctl_t;

    typedef struct packed {
        logic timer_expired;
        logic vec_write;
        logic tx_list_write;
        logic rx_list_write;
    } bcr_evt_t;

endpackage

// ### rtl/bcr_mask_write.sv
`timescale 1ns/1ps
`include "bcr_cfg.svh"

module bcr_mask_write import bcr_pkg::*; #(
    parameter int WIDTH = `BCR_DATA_W
) (
    input wire logic [WIDTH-1:0] cur,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic we,
    input wire logic [WIDTH-1:0] mask,
    output logic [WIDTH-1:0] nxt
);

    logic [WIDTH-1:0] eff;

    always_comb begin
        eff = we ? mask : '0;
        nxt = (cur & ~eff) | (wdata & eff);
    end

endmodule

// ### rtl/bcr_regs.sv
`timescale 1ns/1ps
`include "bcr_cfg.svh"

module bcr_regs import bcr_pkg::*; #(
    parameter int DATA_W = `BCR_DATA_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire bcr_req_t cpu_req,
    output bcr_rsp_t cpu_rsp,
    input wire bcr_req_t host_req,
    output bcr_rsp_t host_rsp,
    input wire bcr_evt_t evt_in,
    input wire logic fuse_good,
    input wire logic link_sense,
    input wire logic strap_one,
    input wire logic strap_two,
    output bcr_ctl_t ctl,
    output logic station_id_rom_sel,
    output logic [2:0] lamp,
    output logic cpu_irq_level2
);

    logic [DATA_W-1:0] control_status;
    logic [DATA_W-1:0] evt;
    logic cpu_sel;
    logic cpu_csr_hit;
    logic cpu_evt_hit;
    logic host_csr_hit;
    logic host_evt_hit;
    logic cpu_csr_we;
    logic cpu_evt_we;
    logic host_csr_we;
    logic host_evt_we;
    logic soft_hit;
    logic [DATA_W-1:0] csr_after_cpu;
    logic [DATA_W-1:0] csr_after_host;
    logic [DATA_W-1:0] evt_after_cpu;
    logic [DATA_W-1:0] evt_after_host;
    logic [DATA_W-1:0] next_csr;
    logic [DATA_W-1:0] next_evt;
    logic [DATA_W-1:0] evt_set;
    logic [DATA_W-1:0] csr_view;
    logic [DATA_W-1:0] evt_view;

    // Address decode
    always_comb begin
        // Select pair read bit 22 first, so the gate sits at 0x40xxxx
        cpu_sel = cpu_req.valid && ({cpu_req.addr[`BCR_SEL_LO], cpu_req.addr[`BCR_SEL_HI]} == `BCR_SEL_GATE);
        cpu_csr_hit = cpu_sel && (cpu_req.addr == `BCR_CSR_ADDR);
        cpu_evt_hit = cpu_sel && (cpu_req.addr == `BCR_EVT_ADDR);
        host_csr_hit = host_req.valid && (host_req.addr == `BCR_CSR_ADDR);
        host_evt_hit = host_req.valid && (host_req.addr == `BCR_EVT_ADDR);
        cpu_csr_we = cpu_csr_hit && cpu_req.wr;
        cpu_evt_we = cpu_evt_hit && cpu_req.wr;
        host_csr_we = host_csr_hit && host_req.wr;
        host_evt_we = host_evt_hit && host_req.wr;
        soft_hit = host_csr_we && host_req.wdata[`BCR_CSR_SOFT_CLEAR];
    end

    // Processor first, host last: host wins a shared bit in a tie
    bcr_mask_write #(.WIDTH(DATA_W)) u_csr_cpu (
        .cur(control_status),
        .wdata(cpu_req.wdata),
        .we(cpu_csr_we),
        .mask(`BCR_CSR_CPU_WR),
        .nxt(csr_after_cpu)
    );

    bcr_mask_write #(.WIDTH(DATA_W)) u_csr_host (
        .cur(csr_after_cpu),
        .wdata(host_req.wdata),
        .we(host_csr_we),
        .mask(`BCR_CSR_HOST_WR),
        .nxt(csr_after_host)
    );

    bcr_mask_write #(.WIDTH(DATA_W)) u_evt_cpu (
        .cur(evt),
        .wdata(cpu_req.wdata),
        .we(cpu_evt_we),
        .mask(`BCR_EVT_WR),
        .nxt(evt_after_cpu)
    );

    bcr_mask_write #(.WIDTH(DATA_W)) u_evt_host (
        .cur(evt_after_cpu),
        .wdata(host_req.wdata),
        .we(host_evt_we),
        .mask(`BCR_EVT_WR),
        .nxt(evt_after_host)
    );

    // New events
    always_comb begin
        evt_set = '0;
        evt_set[`BCR_EVT_TIMER] = evt_in.timer_expired;
        evt_set[`BCR_EVT_CSR_WR] = host_csr_we;
        evt_set[`BCR_EVT_VEC_WR] = evt_in.vec_write;
        evt_set[`BCR_EVT_TXL_WR] = evt_in.tx_list_write;
        evt_set[`BCR_EVT_RXL_WR] = evt_in.rx_list_write;
    end

    // Soft clear wipes all but the kept bits
    always_comb begin
        if (soft_hit) begin
            next_csr = csr_after_host & `BCR_CSR_KEEP;
            next_evt = evt_after_host & `BCR_EVT_KEEP;
        end else begin
            next_csr = csr_after_host & `BCR_CSR_STORED;
            next_evt = evt_after_host;
        end
    end

    // Control/status storage; soft_clear itself never stays set
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_status <= `BCR_CSR_RST;
        end else begin
            control_status <= next_csr;
        end
    end

    // Event storage; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            evt <= `BCR_EVT_RST;
        end else begin
            evt <= (next_evt & `BCR_EVT_WR) | (evt_set & `BCR_EVT_FLAGS);
        end
    end

    // Read views
    always_comb begin
        csr_view = control_status & `BCR_CSR_STORED;
        csr_view[`BCR_CSR_SOFT_CLEAR] = 1'b0;
        csr_view[`BCR_CSR_FUSE_GOOD] = fuse_good;
        csr_view[`BCR_CSR_LINK_SENSE] = link_sense;
        evt_view = evt & `BCR_EVT_WR;
        evt_view[`BCR_EVT_STRAP_ONE] = strap_one;
        evt_view[`BCR_EVT_STRAP_TWO] = strap_two;
    end

    // Processor answer, one cycle after the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_rsp <= '0;
        end else begin
            cpu_rsp.ack <= cpu_sel;
            if (cpu_csr_hit && !cpu_req.wr) begin
                cpu_rsp.rdata <= csr_view;
            end else if (cpu_evt_hit && !cpu_req.wr) begin
                cpu_rsp.rdata <= evt_view;
            end else begin
                cpu_rsp.rdata <= 16'h0000;
            end
        end
    end

    // Host answer, one cycle after the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_rsp <= '0;
        end else begin
            host_rsp.ack <= host_req.valid;
            if (host_csr_hit && !host_req.wr) begin
                host_rsp.rdata <= csr_view;
            end else if (host_evt_hit && !host_req.wr) begin
                host_rsp.rdata <= evt_view;
            end else begin
                host_rsp.rdata <= 16'h0000;
            end
        end
    end

    // Control outputs straight from the stored bits
    always_comb begin
        ctl.rx_path_on = control_status[`BCR_CSR_RX_PATH_ON];
        ctl.boot_load_sel = control_status[`BCR_CSR_BOOT_SEL];
        ctl.irq_gate = control_status[`BCR_CSR_IRQ_GATE];
        ctl.tx_done_irq = control_status[`BCR_CSR_TX_DONE];
        ctl.inner_loop = control_status[`BCR_CSR_INNER_LOOP];
        ctl.outer_loop = control_status[`BCR_CSR_OUTER_LOOP];
        ctl.watchdog_on = control_status[`BCR_CSR_WATCHDOG];
        ctl.rx_done_irq = control_status[`BCR_CSR_RX_DONE];
        ctl.absent_flag = control_status[`BCR_CSR_ABSENT];
        ctl.tx_list_bad = control_status[`BCR_CSR_TX_LIST_BAD];
        ctl.rx_list_bad = control_status[`BCR_CSR_RX_LIST_BAD];
        ctl.parity_fault = control_status[`BCR_CSR_PARITY];
        station_id_rom_sel = evt[`BCR_EVT_ROM_SEL];
        lamp = evt[`BCR_EVT_LAMP_LO+2:`BCR_EVT_LAMP_LO];
        cpu_irq_level2 = |(evt & `BCR_EVT_FLAGS);
    end

endmodule

// ### tb/bcr_regs_props.sv
`timescale 1ns/1ps
module bcr_regs_props import bcr_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire bcr_req_t cpu_req,
    input wire bcr_rsp_t cpu_rsp,
    input wire bcr_req_t host_req,
    input wire bcr_rsp_t host_rsp,
    input wire bcr_evt_t evt_in,
    input wire logic fuse_good,
    input wire logic link_sense,
    input wire logic strap_one,
    input wire logic strap_two,
    input wire bcr_ctl_t ctl,
    input wire logic station_id_rom_sel,
    input wire logic [2:0] lamp,
    input wire logic cpu_irq_level2
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic hc = host_req.valid && host_req.addr == 24'h40FF0E;
    wire logic hw = hc && host_req.wr;
    wire logic cw = cpu_req.valid && cpu_req.wr && cpu_req.addr == 24'h40FF0E;
    wire logic he = host_req.valid && !host_req.wr && host_req.addr == 24'h40FF1E;
    wire logic ce = cpu_req.valid && cpu_req.wr && cpu_req.addr == 24'h40FF1E;
    property p_ack; host_req.valid |=> host_rsp.ack; endproperty
    a_ack: assert property (p_ack) else $error("host ack missing");
    property p_gate; cpu_req.valid && {cpu_req.addr[22], cpu_req.addr[23]} != 2'h2 |=> !cpu_rsp.ack; endproperty
    a_gate: assert property (p_gate) else $error("ack outside gate");
    property p_cro; cw && !host_req.valid && !$past(host_req.valid) |=>
        ctl.irq_gate == $past(ctl.irq_gate) && ctl.rx_path_on == $past(ctl.rx_path_on); endproperty
    a_cro: assert property (p_cro) else $error("processor changed host bit");
    property p_hro; hw && !host_req.wdata[1] && !cpu_req.valid && !$past(host_req.valid) |=>
        ctl.parity_fault == $past(ctl.parity_fault) && ctl.absent_flag == $past(ctl.absent_flag); endproperty
    a_hro: assert property (p_hro) else $error("host changed processor bit");
    property p_fuse; hc && !host_req.wr |=>
        host_rsp.rdata[13:11] == {$past(link_sense), $past(fuse_good), 1'b0}; endproperty
    a_fuse: assert property (p_fuse) else $error("live bits wrong");
    property p_soft; hw && host_req.wdata[1] && !cpu_req.valid ##1 !cpu_req.valid && !host_req.valid |=>
        !ctl.rx_path_on && !ctl.irq_gate && ctl.tx_list_bad == $past(ctl.tx_list_bad, 2)
        && lamp == $past(lamp, 2);
    endproperty
    a_soft: assert property (p_soft) else $error("soft clear wrong");
    property p_strap; he |=> host_rsp.rdata[12:7] == {$past(strap_two), 5'h00} &&
        host_rsp.rdata[5] == $past(strap_one); endproperty
    a_strap: assert property (p_strap) else $error("strap bits wrong");
    property p_lamp; ce && !host_req.valid && !$past(host_req.valid) |=> lamp == $past(cpu_req.wdata[15:13])
        && station_id_rom_sel == $past(cpu_req.wdata[6]); endproperty
    a_lamp: assert property (p_lamp) else $error("lamp write wrong");
    property p_irq; |evt_in |=> cpu_irq_level2; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    c_soft: cover property (hw && host_req.wdata[1]);
    c_gate: cover property (cpu_req.valid && {cpu_req.addr[22], cpu_req.addr[23]} != 2'h2);
    c_tmr: cover property (evt_in.timer_expired);
endmodule
bind bcr_regs bcr_regs_props u_props (.core_clk, .rst, .cpu_req, .cpu_rsp, .host_req, .host_rsp, .evt_in,
    .fuse_good, .link_sense, .strap_one, .strap_two, .ctl, .station_id_rom_sel, .lamp, .cpu_irq_level2);

// ### tb/bcr_master.sv
`timescale 1ns/1ps
module bcr_master import bcr_pkg::*; (
    input wire logic core_clk,
    output bcr_req_t req,
    input wire bcr_rsp_t rsp
);
    initial begin
        req = '0;
    end
    task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic k);
        @(posedge core_clk);
        #1;
        req = '{1'b1, w, a, d};
        @(posedge core_clk);
        #1;
        // Released lines show the inverse
        req = '{1'b0, 1'b0, ~a, ~d};
        k = rsp.ack;
        q = rsp.rdata;
    endtask
endmodule

// ### tb/backport_control_registers_bench.sv
`timescale 1ns/1ps
module backport_control_registers_bench import bcr_pkg::*;;
    logic core_clk, rst, fuse_good, link_sense, strap_one, strap_two, station_id_rom_sel, cpu_irq_level2;
    logic k, k2;
    logic [2:0] lamp;
    logic [15:0] q, r;
    bcr_req_t cpu_req, host_req;
    bcr_rsp_t cpu_rsp, host_rsp;
    bcr_evt_t evt_in;
    bcr_ctl_t ctl;
    int fails, checked;
    localparam logic [23:0] csr_a = 24'h40FF0E;
    localparam logic [23:0] evt_a = 24'h40FF1E;
    bcr_regs DUT (.core_clk, .rst, .cpu_req, .cpu_rsp, .host_req, .host_rsp, .evt_in, .fuse_good,
        .link_sense, .strap_one, .strap_two, .ctl, .station_id_rom_sel, .lamp, .cpu_irq_level2);
    bcr_master u_cpu (.core_clk, .req(cpu_req), .rsp(cpu_rsp));
    bcr_master u_host (.core_clk, .req(host_req), .rsp(host_rsp));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task stop_test;
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task t_reset;
        u_host.acc(1'b0, csr_a, 16'h0000, q, k);
        chk(q, 16'h3000);
        u_host.acc(1'b0, evt_a, 16'h0000, q, k);
        chk(q, 16'h1020);
    endtask
    task t_rights;
        u_host.acc(1'b1, csr_a, 16'hFFFD, q, k);
        u_host.acc(1'b0, csr_a, 16'h0000, q, k);
        chk(q, 16'hB7C9);
        u_cpu.acc(1'b1, csr_a, 16'hFFFF, q, k);
        u_cpu.acc(1'b0, csr_a, 16'h0000, q, k);
        chk(q, 16'hF7FD);
        u_host.acc(1'b1, csr_a, 16'h0000, q, k);
        u_cpu.acc(1'b0, csr_a, 16'h0000, q, k);
        chk(q, 16'h7034);
        u_cpu.acc(1'b1, csr_a, 16'hFFFF, q, k);
        u_cpu.acc(1'b0, csr_a, 16'h0000, q, k);
        chk(q, 16'hF2B4);
    endtask
    task t_soft;
        u_cpu.acc(1'b1, evt_a, 16'hE040, q, k);
        u_host.acc(1'b1, csr_a, 16'h0002, q, k);
        u_cpu.acc(1'b0, csr_a, 16'h0000, q, k);
        chk(q, 16'h3030);
        u_cpu.acc(1'b0, evt_a, 16'h0000, q, k);
        chk(q, 16'hF022);
        chk({15'h0000, cpu_irq_level2}, 16'h0001);
    endtask
    task t_events;
        for (int i = 0; i < 4; i++) begin
            u_cpu.acc(1'b1, evt_a, 16'h0000, q, k);
            chk({15'h0000, cpu_irq_level2}, 16'h0000);
            @(posedge core_clk);
            #1;
            evt_in = bcr_evt_t'(4'h8 >> i);
            @(posedge core_clk);
            #1;
            evt_in = '0;
            u_cpu.acc(1'b0, evt_a, 16'h0000, q, k);
            chk(q, 16'h1020 | (i == 0 ? 16'h0001 : 16'h0002 << i));
        end
    endtask
    task t_gate;
        u_cpu.acc(1'b0, 24'h00FF0E, 16'h0000, q, k);
        chk({15'h0000, k}, 16'h0000);
        u_cpu.acc(1'b0, 24'h40FF00, 16'h0000, q, k);
        chk(q, 16'h0000);
        chk({15'h0000, k}, 16'h0001);
        u_cpu.acc(1'b0, 24'h800000, 16'h0000, q, k);
        chk({15'h0000, k}, 16'h0000);
        u_host.acc(1'b0, 24'h40FF00, 16'h0000, q, k);
        chk(q, 16'h0000);
    endtask
    task t_both;
        fork
            u_cpu.acc(1'b1, csr_a, 16'h0000, q, k);
            u_host.acc(1'b1, csr_a, 16'h0200, r, k2);
        join
        u_cpu.acc(1'b0, csr_a, 16'h0000, q, k);
        chk(q, 16'h3200);
    endtask
    initial begin
        evt_in = '0;
        fuse_good = 1;
        link_sense = 1;
        strap_one = 1;
        strap_two = 1;
        fails = 0;
        checked = 0;
        rst = 1;
        repeat (16) @(posedge core_clk);
        #1;
        rst = 0;
        t_reset;
        t_rights;
        t_soft;
        t_events;
        t_gate;
        t_both;
        stop_test;
    end
    initial begin
        #20000;
        fails++;
        stop_test;
    end
endmodule
